/* File: include/fcs_pkg.sv */
// constants and types of the flash command sequencer (host side)
package fcs_pkg;
  // bus and counter widths
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CMD_W  = 11;
  localparam int CNT_W  = 12;
  // command addresses, low decode bits only
  localparam logic [CMD_W-1:0] A_UNL1 = 11'h555;
  localparam logic [CMD_W-1:0] A_UNL2 = 11'h2AA;
  localparam logic [CMD_W-1:0] A_ANY  = 11'h000;
  // command data codes
  localparam logic [7:0] D_UNL1   = 8'hAA;
  localparam logic [7:0] D_UNL2   = 8'h55;
  localparam logic [7:0] D_RESET  = 8'hF0;
  localparam logic [7:0] D_SIG    = 8'h90;
  localparam logic [7:0] D_PROG   = 8'hA0;
  localparam logic [7:0] D_BYP    = 8'h20;
  localparam logic [7:0] D_ESETUP = 8'h80;
  localparam logic [7:0] D_CHIP   = 8'h10;
  localparam logic [7:0] D_BLOCK  = 8'h30;
  localparam logic [7:0] D_SUSP   = 8'hB0;
  localparam logic [7:0] D_RESUME = 8'h30;
  localparam logic [7:0] D_BEXIT1 = 8'h90;
  localparam logic [7:0] D_BEXIT2 = 8'h00;
  // status byte bit positions
  localparam int B_TOG   = 6;
  localparam int B_FAIL  = 5;
  localparam int B_TIMER = 3;
  // timing
  localparam int CLK_MHZ    = 50;
  localparam int T_WP_NS    = 100;
  localparam int T_RD_NS    = 120;
  localparam int T_WIN_US   = 50;
  localparam int T_SUSP_US  = 15;
  localparam int T_ABORT_US = 10;
  localparam logic [CNT_W-1:0] WP_CYC    = CNT_W'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RD_CYC    = CNT_W'((T_RD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] WIN_CYC   = CNT_W'(T_WIN_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] SUSP_CYC  = CNT_W'(T_SUSP_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ABORT_CYC = CNT_W'(T_ABORT_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] WIN_MARGIN = 12'h010;
  // user operations
  typedef enum logic [3:0] {
    OP_READ       = 4'h0,
    OP_RESET      = 4'h1,
    OP_SIGNATURE  = 4'h2,
    OP_PROGRAM    = 4'h3,
    OP_BYP_ENTER  = 4'h4,
    OP_BYP_PROG   = 4'h5,
    OP_BYP_EXIT   = 4'h6,
    OP_CHIP_ERASE = 4'h7,
    OP_BLOCK_ERASE = 4'h8,
    OP_ADD_BLOCK  = 4'h9,
    OP_SUSPEND    = 4'hA,
    OP_RESUME     = 4'hB
  } fcs_op_t;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEQ  = 3'h1,
    ST_POLL = 3'h3,
    ST_WAIT = 3'h2,
    ST_RUN  = 3'h6
  } fcs_state_t;
  // pin cycle phases
  typedef enum logic [1:0] {
    BP_IDLE = 2'h0,
    BP_SET  = 2'h1,
    BP_STRB = 2'h3,
    BP_HOLD = 2'h2
  } fcs_bph_t;
endpackage : fcs_pkg

/* File: src/fcs_bus.sv */
// single read or write cycle on the flash pins
`timescale 1ns/10ps
`default_nettype none
module fcs_bus #(
  parameter int ADDR_W = fcs_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // cycle request
  input  wire logic              go,
  input  wire logic              wr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  output logic                   done,
  output logic [7:0]             rdata,
  // flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [7:0]             flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [7:0]        flash_dq_in,
  output logic                   flash_ce_b,
  output logic                   flash_we_b,
  output logic                   flash_oe_b
);
  import fcs_pkg::*;

  fcs_bph_t             ph;
  logic [CNT_W-1:0]     cnt;
  logic                 wr_q;
  logic [7:0]           dq_s1;
  logic [7:0]           dq_s2;

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencing
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ph  <= BP_IDLE;
      cnt <= '0;
    end else begin
      case (ph)
        BP_IDLE: if (go) ph <= BP_SET;
        BP_SET: begin
          ph  <= BP_STRB;
          cnt <= wr_q ? WP_CYC - 12'h001 : RD_CYC - 12'h001;
        end
        BP_STRB: begin
          if (cnt == '0) ph <= BP_HOLD;
          else cnt <= cnt - 12'h001;
        end
        default: ph <= BP_IDLE;
      endcase
    end
  end

  // pins: address and data held from before the strobe falls until after it rises
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flash_addr   <= '0;
      flash_dq_out <= '0;
      flash_dq_oe  <= 1'b0;
      flash_ce_b   <= 1'b1;
      flash_we_b   <= 1'b1;
      flash_oe_b   <= 1'b1;
      wr_q         <= 1'b0;
    end else begin
      case (ph)
        BP_IDLE: if (go) begin
          flash_addr   <= addr;
          flash_dq_out <= wdata;
          flash_dq_oe  <= wr;
          flash_ce_b   <= 1'b0;
          wr_q         <= wr;
        end
        BP_SET: begin
          flash_we_b <= !wr_q;
          flash_oe_b <= wr_q;
        end
        BP_STRB: if (cnt == '0) begin
          flash_we_b <= 1'b1;
          flash_oe_b <= 1'b1;
        end
        default: begin
          flash_ce_b  <= 1'b1;
          flash_dq_oe <= 1'b0;
        end
      endcase
    end
  end

  // read data passes two flops before it is sampled
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      rdata <= '0;
      done  <= 1'b0;
    end else begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
      done  <= (ph == BP_HOLD);
      if (ph == BP_STRB && cnt == '0 && !wr_q) rdata <= dq_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  strobe_excl_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(!flash_we_b && !flash_oe_b)) else $error("write and output strobes overlap");
  drive_oe_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    flash_dq_oe |-> flash_oe_b) else $error("data driven while output enabled");
  write_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !flash_we_b |=> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved around write strobe");
  pulse_width_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(flash_we_b) |-> !flash_we_b [*5] ##1 flash_we_b)
    else $error("write pulse width wrong");
  cycle_done_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(flash_ce_b) |-> done) else $error("cycle end without done");
endmodule : fcs_bus
`default_nettype wire

/* File: src/fcs_ctrl.sv */
// host controller issuing command sequences to a parallel flash
// Functional notes
// - F0 alone, or after the unlock prefix, returns the flash to read mode.
// - Multi-write commands open with AA@555, 55@2AA; then 90@555 is signature.
// - Program: prefix, A0@555, then target address with value.
// - 20@555 enters bypass; only bypass program or bypass exit then (the code also writes F0 after a failed bypass program).
// - Bypass exit is 90 then 00 to any address.
// - Chip erase: prefix, 80@555, prefix, 10@555.
// - After an erase the flash reads array unless failed; reset clears that.
// - Block erase ends 30 at a block address; repeat to add blocks.
// - Erase starts 50 us after last block select; add within window.
// - B0 suspends the block erase within 15 us.
// - 30 resumes; suspend and resume may repeat.
`timescale 1ns/10ps
`default_nettype none
module fcs_ctrl #(
  parameter int ADDR_W = fcs_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // user request
  input  wire logic              req,
  input  wire fcs_pkg::fcs_op_t  op,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  // user answer
  output logic                   ready,
  output logic                   done,
  output logic                   fail,
  output logic                   refused,
  output logic [7:0]             rdata,
  // mode status
  output logic                   bypass_on,
  output logic                   erase_run,
  output logic                   erase_suspended,
  output logic                   window_open,
  // flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [7:0]             flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [7:0]        flash_dq_in,
  output logic                   flash_ce_b,
  output logic                   flash_we_b,
  output logic                   flash_oe_b
);
  import fcs_pkg::*;

  fcs_state_t           state;
  fcs_state_t           next_state;
  fcs_op_t              op_q;
  logic [ADDR_W-1:0]    addr_q;
  logic [7:0]           wdata_q;
  logic [2:0]           idx;
  logic                 bus_go;
  logic                 bus_pend;
  logic                 bus_done;
  logic                 bus_wr;
  logic [ADDR_W-1:0]    bus_addr;
  logic [7:0]           bus_wdata;
  logic [7:0]           bus_rdata;
  logic [CMD_W+8:0]     word;
  logic [CNT_W-1:0]     wait_cnt;
  logic [CNT_W-1:0]     win_cnt;
  logic                 poll_n;
  logic                 tog_prev;
  logic                 fail_pend;
  logic                 fail_q;
  logic                 accept;
  logic                 seq_fin;
  logic                 poll_end;
  logic                 poll_same;
  logic                 fail_det;
  logic                 to_done;

  ////////////////////////////////////////////////////////////////////////////
  // functions
  function automatic logic [2:0] seq_len(input fcs_op_t o);
    case (o)
      OP_RESET, OP_ADD_BLOCK, OP_SUSPEND, OP_RESUME: seq_len = 3'h1;
      OP_BYP_PROG, OP_BYP_EXIT:                      seq_len = 3'h2;
      OP_SIGNATURE, OP_BYP_ENTER:                    seq_len = 3'h3;
      OP_PROGRAM:                                    seq_len = 3'h4;
      OP_CHIP_ERASE, OP_BLOCK_ERASE:                 seq_len = 3'h6;
      default:                                       seq_len = 3'h0;
    endcase
  endfunction : seq_len

  // word i of a sequence: {use target address, command address, data}
  function automatic logic [CMD_W+8:0] seq_word(input fcs_op_t o, input logic [2:0] i,
                                                input logic [7:0] d);
    logic [CMD_W+8:0] w;
    w = {1'b0, A_ANY, D_RESET};
    case (o)
      OP_RESET:     w = {1'b0, A_ANY, D_RESET};
      OP_BYP_PROG:  w = (i == 3'h0) ? {1'b0, A_ANY, D_PROG} : {1'b1, A_ANY, d};
      OP_BYP_EXIT:  w = (i == 3'h0) ? {1'b0, A_ANY, D_BEXIT1} : {1'b0, A_ANY, D_BEXIT2};
      OP_ADD_BLOCK: w = {1'b1, A_ANY, D_BLOCK};
      OP_SUSPEND:   w = {1'b0, A_ANY, D_SUSP};
      OP_RESUME:    w = {1'b0, A_ANY, D_RESUME};
      default: begin
        if (i == 3'h0 || i == 3'h3) w = {1'b0, A_UNL1, D_UNL1};
        else if (i == 3'h1 || i == 3'h4) w = {1'b0, A_UNL2, D_UNL2};
        else if (i == 3'h2) begin
          case (o)
            OP_SIGNATURE: w = {1'b0, A_UNL1, D_SIG};
            OP_PROGRAM:   w = {1'b0, A_UNL1, D_PROG};
            OP_BYP_ENTER: w = {1'b0, A_UNL1, D_BYP};
            default:      w = {1'b0, A_UNL1, D_ESETUP};
          endcase
        end else if (o == OP_CHIP_ERASE) w = {1'b0, A_UNL1, D_CHIP};
        else w = {1'b1, A_ANY, D_BLOCK};
        if (o == OP_PROGRAM && i == 3'h3) w = {1'b1, A_ANY, d};
      end
    endcase
    seq_word = w;
  endfunction : seq_word

  // only whole, legal sequences for the present mode are started on request; a failure starts the F0 reset write in any mode, bypass included
  function automatic logic op_ok(input fcs_op_t o, input logic run, input logic byp,
                                 input logic susp, input logic win);
    if (run) op_ok = (o == OP_ADD_BLOCK) ? win : (o == OP_SUSPEND || o == OP_RESET);
    else if (byp) op_ok = o inside {OP_BYP_PROG, OP_BYP_EXIT, OP_READ};
    else if (susp) op_ok = o inside {OP_READ, OP_PROGRAM, OP_SIGNATURE, OP_RESET,
                                     OP_RESUME};
    else op_ok = o inside {OP_RESET, OP_SIGNATURE, OP_PROGRAM, OP_BYP_ENTER,
                           OP_CHIP_ERASE, OP_BLOCK_ERASE, OP_READ};
  endfunction : op_ok

  ////////////////////////////////////////////////////////////////////////////
  // decode of the present cycle
  always_comb begin
    accept    = ready && req && op_ok(op, erase_run, bypass_on, erase_suspended,
                                      window_open && (win_cnt < WIN_CYC - WIN_MARGIN));
    seq_fin   = state == ST_SEQ && bus_done && (op_q == OP_READ || idx == seq_len(op_q) - 3'h1);
    poll_end  = state == ST_POLL && bus_done && poll_n;
    poll_same = tog_prev == bus_rdata[B_TOG];
    fail_det  = poll_end && !poll_same && fail_pend && bus_rdata[B_FAIL];
    word      = seq_word(op_q, idx, wdata_q);
    bus_wr    = state == ST_SEQ && op_q != OP_READ;
    bus_wdata = word[7:0];
    // command addresses drive only the low decode bits
    bus_addr  = (state != ST_SEQ || op_q == OP_READ || word[CMD_W+8]) ? addr_q
              : {{(ADDR_W-CMD_W){1'b0}}, word[CMD_W+7:8]};
  end

  // next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (accept) next_state = ST_SEQ;
      ST_RUN:  next_state = accept ? ST_SEQ : ST_POLL;
      ST_SEQ: if (seq_fin) begin
        case (op_q)
          OP_PROGRAM, OP_BYP_PROG, OP_CHIP_ERASE: next_state = ST_POLL;
          OP_BLOCK_ERASE, OP_ADD_BLOCK, OP_RESUME: next_state = ST_RUN;
          OP_SUSPEND: next_state = ST_WAIT;
          OP_RESET: next_state = (fail_q || erase_run) ? ST_WAIT : ST_IDLE;
          default: next_state = ST_IDLE;
        endcase
      end
      ST_POLL: if (poll_end) begin
        if (poll_same) next_state = ST_IDLE;
        else if (fail_det) next_state = ST_SEQ;
        else if (erase_run) next_state = ST_RUN;
      end
      ST_WAIT: if (wait_cnt == '0) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  assign to_done = state != next_state &&
                   (next_state == ST_IDLE || (state == ST_SEQ && next_state == ST_RUN));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) state <= ST_IDLE;
    else state <= next_state;
  end

  // request capture and sequence position
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      op_q    <= OP_READ;
      addr_q  <= '0;
      wdata_q <= '0;
      idx     <= '0;
      fail_q  <= 1'b0;
    end else if (accept) begin
      op_q    <= op;
      addr_q  <= addr;
      wdata_q <= wdata;
      idx     <= '0;
      fail_q  <= 1'b0;
    end else if (fail_det) begin
      op_q   <= OP_RESET;
      idx    <= '0;
      fail_q <= 1'b1;
    end else if (state == ST_SEQ && bus_done) begin
      idx <= idx + 3'h1;
    end
  end

  // one pin cycle at a time
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_go   <= 1'b0;
      bus_pend <= 1'b0;
    end else begin
      bus_go <= (state == ST_SEQ || state == ST_POLL) && !bus_pend && !bus_go;
      if (bus_go) bus_pend <= 1'b1;
      else if (bus_done) bus_pend <= 1'b0;
    end
  end

  // status polling in read pairs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      poll_n    <= 1'b0;
      tog_prev  <= 1'b0;
      fail_pend <= 1'b0;
    end else begin
      if (state == ST_POLL && bus_done) begin
        poll_n <= !poll_n;
        if (!poll_n) tog_prev <= bus_rdata[B_TOG];
      end
      if (accept) fail_pend <= 1'b0;
      else if (poll_end && !poll_same && bus_rdata[B_FAIL]) fail_pend <= 1'b1;
    end
  end

  // settle delays after suspend and abort
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) wait_cnt <= '0;
    else if (seq_fin) wait_cnt <= (op_q == OP_SUSPEND) ? SUSP_CYC : ABORT_CYC;
    else if (state == ST_WAIT && wait_cnt != '0) wait_cnt <= wait_cnt - 12'h001;
  end

  // block selection window
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      win_cnt     <= '0;
      window_open <= 1'b0;
    end else if (seq_fin && (op_q == OP_BLOCK_ERASE || op_q == OP_ADD_BLOCK)) begin
      win_cnt     <= '0;
      window_open <= 1'b1;
    end else if (window_open) begin
      win_cnt <= win_cnt + 12'h001;
      if (win_cnt >= WIN_CYC - 12'h001 || !erase_run) window_open <= 1'b0;
      else if (poll_end && bus_rdata[B_TIMER]) window_open <= 1'b0;
    end
  end

  // mode flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bypass_on       <= 1'b0;
      erase_run       <= 1'b0;
      erase_suspended <= 1'b0;
    end else begin
      if (seq_fin && op_q == OP_BYP_ENTER) bypass_on <= 1'b1;
      else if (seq_fin && op_q == OP_BYP_EXIT) bypass_on <= 1'b0;
      if (seq_fin && (op_q == OP_BLOCK_ERASE || op_q == OP_RESUME)) begin
        erase_run       <= 1'b1;
        erase_suspended <= 1'b0;
      end else if (seq_fin && op_q == OP_SUSPEND) begin
        erase_run       <= 1'b0;
        erase_suspended <= 1'b1;
      end else if ((seq_fin && op_q == OP_RESET) || (poll_end && poll_same) || fail_det) begin
        erase_run <= 1'b0;
      end
    end
  end

  // user answer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ready   <= 1'b0;
      done    <= 1'b0;
      fail    <= 1'b0;
      refused <= 1'b0;
      rdata   <= '0;
    end else begin
      ready   <= next_state == ST_IDLE || next_state == ST_RUN;
      done    <= to_done;
      fail    <= to_done && fail_q;
      refused <= ready && req && !accept;
      if (state == ST_SEQ && bus_done && op_q == OP_READ) rdata <= bus_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin cycle engine
  fcs_bus #(.ADDR_W(ADDR_W)) u_bus (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .go           (bus_go),
    .wr           (bus_wr),
    .addr         (bus_addr),
    .wdata        (bus_wdata),
    .done         (bus_done),
    .rdata        (bus_rdata),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in),
    .flash_ce_b   (flash_ce_b),
    .flash_we_b   (flash_we_b),
    .flash_oe_b   (flash_oe_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  fail_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    bus_go && state == ST_SEQ && fail_q |-> bus_wdata == D_RESET)
    else $error("failure not followed by reset write");
  window_add_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    bus_go && op_q == OP_ADD_BLOCK |-> window_open && win_cnt < WIN_CYC)
    else $error("block added outside window");
  bypass_only_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    bus_go && bus_wr && bypass_on |-> op_q inside {OP_BYP_PROG, OP_BYP_EXIT, OP_RESET})
    else $error("illegal command in bypass");
  refuse_bad_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ready && req && !accept |=> refused && state != ST_SEQ)
    else $error("illegal request not refused");
endmodule : fcs_ctrl
`default_nettype wire

/* File: test/fcs_flash_model.sv */
// behavioural flash device seen from the sequencer's pins
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [7:0] SIG_CODE = 8'h3C, // arbitrary signature value
  parameter int         ERS_CYC  = 3000,
  parameter logic [7:0] PROT     = 8'h00, // write-protected blocks
  parameter int         BAD_ADDR = 32'h0005_0ABC // programming this byte fails
) (
  // timing clock
  input  wire logic              clk_sys,
  // flash pins
  input  wire logic [ADDR_W-1:0] flash_addr,
  input  wire logic [7:0]        flash_dq_out,
  input  wire logic              flash_dq_oe,
  input  wire logic              flash_ce_b,
  input  wire logic              flash_we_b,
  input  wire logic              flash_oe_b,
  output logic [7:0]             flash_dq_in
);
  logic [7:0]        mem [int];
  logic [ADDR_W-1:0] a_q = '0;
  logic [7:0]        d, blk = 8'h00, pv = 8'h00, outv = 8'h00, lastv = 8'h00;
  logic              byp = 0, sig = 0, ers = 0, chip = 0, susp = 0, win = 0, tog = 0, bad = 0;
  int                stp = 0, pg = 0, eb = 0, wc = 0, ks[$];
  wire               wstb = flash_ce_b | flash_we_b;
  wire               rstb = flash_ce_b | flash_oe_b;
  ////////////////////////////////////////////////////////////
  // address taken on strobe fall
  always @(negedge wstb) a_q = flash_addr;
  // command decode on strobe rise
  always @(posedge wstb) begin
    d = flash_dq_oe ? flash_dq_out : ~flash_dq_out; // an undriven bus gives garbage
    if (chip || pg > 0) stp = 0;
    else if (ers && !susp) begin
      if (d == D_SUSP) susp = 1;
      else if (d == D_RESET) ers = 0;
      else if (d == D_BLOCK && win) wc = WIN_CYC;
      if (d == D_BLOCK && win) blk[a_q[18:16]] = 1;
    end else if (stp == 3) begin
      if (!PROT[a_q[18:16]] && int'(a_q) != BAD_ADDR)
        mem[int'(a_q)] = (mem.exists(int'(a_q)) ? mem[int'(a_q)] : 8'hFF) & d;
      bad = int'(a_q) == BAD_ADDR;
      pv = d;
      pg = bad ? 0 : 200;
      stp = 0;
    end else if (d == D_RESET) begin
      stp = 0;
      sig = 0;
      bad = 0;
    end else if (byp) begin
      byp = !(stp == 8 && d == D_BEXIT2);
      stp = (stp == 0 && d == D_PROG) ? 3 : (stp == 0 && d == D_BEXIT1) ? 8 : 0;
    end else if (susp && stp == 0 && d == D_RESUME) begin
      susp = 0;
      win = 0;
    end else if (stp inside {0, 4} && a_q[10:0] == A_UNL1 && d == D_UNL1) stp++;
    else if (stp inside {1, 5} && a_q[10:0] == A_UNL2 && d == D_UNL2) stp++;
    else if (stp == 2 && a_q[10:0] == A_UNL1 && d inside {D_SIG, D_PROG, D_BYP, D_ESETUP}) begin
      sig = d == D_SIG;
      byp = d == D_BYP;
      stp = d == D_PROG ? 3 : d == D_ESETUP ? 4 : 0;
    end else if (stp == 6 && (d == D_BLOCK || (d == D_CHIP && a_q[10:0] == A_UNL1))) begin
      chip = d == D_CHIP;
      blk = chip ? 8'hFF : 8'h01 << a_q[18:16];
      ers = 1;
      win = !chip;
      wc = WIN_CYC;
      eb = ERS_CYC;
      stp = 0;
    end else stp = 0;
  end
  // timers, erase completion and the byte offered to reads
  always @(posedge clk_sys) begin
    if (pg > 0) pg = pg - 1;
    if (ers && !susp && win) wc = wc - 1;
    if (wc == 0) win = 0;
    if (ers && !susp && !win) eb = eb - 1;
    if (ers && eb == 0) begin
      ks.delete();
      foreach (mem[k]) if (blk[k[18:16]] && !PROT[k[18:16]]) ks.push_back(k);
      foreach (ks[i]) mem.delete(ks[i]);
      ers = 0;
      chip = 0;
    end
    // offered byte changes after the edge, so the sequencer never races it
    if (pg > 0 || bad || (ers && (!susp || blk[flash_addr[18:16]])))
      outv <= {pg > 0 || bad ? ~pv[7] : susp, tog, bad, 1'b0, ers && !win, 3'b000};
    else if (sig) outv <= SIG_CODE;
    else outv <= mem.exists(int'(flash_addr)) ? mem[int'(flash_addr)] : 8'hFF;
  end
  // toggle per status read; a released bus shows the inverse of the last byte
  always @(posedge rstb) begin
    if (pg > 0 || bad || (ers && !susp)) tog = ~tog;
    lastv = outv;
  end
  assign flash_dq_in = rstb ? ~lastv : outv;
endmodule : fcs_flash_model
`default_nettype wire

/* File: test/flash_command_sequencer_bench.sv */
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer_bench;
  import fcs_pkg::*;
  logic              clk_sys = 0, rst_b = 0, req = 0, ref_q, fl_q, win, doe;
  fcs_op_t           op = OP_READ;
  logic [ADDR_W-1:0] addr = '0, fa, a1, a2, a3;
  logic [7:0]        wdata = 8'h00, rdata, dqo, dqi, v1, v2, v3;
  logic [15:0]       rnd = 16'hE3D4;
  logic              ready, done, fail, refused, byp, run, susp, ce_b, we_b, oe_b;
  int                mismatches = 0, checked = 0, n;
  fcs_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .op(op), .addr(addr),
    .wdata(wdata), .ready(ready), .done(done), .fail(fail), .refused(refused), .rdata(rdata),
    .bypass_on(byp), .erase_run(run), .erase_suspended(susp), .window_open(win),
    .flash_addr(fa), .flash_dq_out(dqo), .flash_dq_oe(doe), .flash_dq_in(dqi),
    .flash_ce_b(ce_b), .flash_we_b(we_b), .flash_oe_b(oe_b));
  fcs_flash_model flash (.clk_sys(clk_sys), .flash_addr(fa), .flash_dq_out(dqo),
    .flash_dq_oe(doe), .flash_ce_b(ce_b), .flash_we_b(we_b), .flash_oe_b(oe_b),
    .flash_dq_in(dqi));
  ////////////////////////////////////////////////////////////
  // clock
  always #10 clk_sys = ~clk_sys;
  // random address in a block, advancing the shift register
  function automatic logic [ADDR_W-1:0] in_blk(input logic [2:0] b);
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return {b, rnd};
  endfunction : in_blk
  // byte comparison
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  // one request, held until taken, then its answer awaited
  task automatic run_op(input fcs_op_t o, input logic [ADDR_W-1:0] a, input logic [7:0] v);
    req <= 1'b1;
    op <= o;
    addr <= a;
    wdata <= v;
    @(negedge clk_sys);
    while (ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    req <= 1'b0;
    for (n = 0; done !== 1'b1 && refused !== 1'b1 && n < 40000; n++) @(negedge clk_sys);
    ref_q = refused;
    fl_q = fail;
    if (n >= 40000) mismatches++;
    @(posedge clk_sys);
  endtask : run_op
  // read one byte and compare it
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    run_op(OP_READ, a, 8'h00);
    cmp("rdata", e, rdata);
  endtask : rd
  // verdict and end of run
  task automatic results();
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  // hang guard
  initial begin
    #1800000;
    mismatches++;
    results();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    repeat (4) begin
      a1 = in_blk(3'h1);
      v1 = rnd[7:0];
      run_op(OP_PROGRAM, a1, v1);
      cmp("fail", 8'h00, {7'h00, fl_q});
      rd(a1, v1);
    end
    // a byte the flash cannot program: failure reported after the reset write
    run_op(OP_PROGRAM, ADDR_W'(flash.BAD_ADDR), 8'h5A);
    cmp("fail", 8'h01, {7'h00, fl_q});
    run_op(OP_SIGNATURE, a1, 8'h00);
    rd(a1, flash.SIG_CODE);
    run_op(OP_RESET, a1, 8'h00);
    rd(a1, v1);
    run_op(OP_BYP_ENTER, a1, 8'h00);
    cmp("bypass_on", 8'h01, {7'h00, byp});
    run_op(OP_CHIP_ERASE, a1, 8'h00);
    cmp("refused", 8'h01, {7'h00, ref_q});
    a2 = in_blk(3'h2);
    v2 = rnd[15:8];
    run_op(OP_BYP_PROG, a2, v2);
    run_op(OP_BYP_EXIT, a2, 8'h00);
    cmp("bypass_on", 8'h00, {7'h00, byp});
    rd(a2, v2);
    // two blocks queued, suspended inside the window, resumed
    run_op(OP_BLOCK_ERASE, a1, 8'h00);
    run_op(OP_ADD_BLOCK, a2, 8'h00);
    cmp("window_open", 8'h01, {7'h00, win});
    run_op(OP_SUSPEND, a1, 8'h00);
    cmp("erase_suspended", 8'h01, {7'h00, susp});
    cmp("window_open", 8'h00, {7'h00, win});
    a3 = in_blk(3'h3);
    v3 = rnd[7:0];
    run_op(OP_PROGRAM, a3, v3);
    rd(a3, v3);
    run_op(OP_RESUME, a1, 8'h00);
    for (n = 0; run === 1'b1 && n < 40000; n++) @(negedge clk_sys);
    cmp("erase_run", 8'h00, {7'h00, run});
    @(posedge clk_sys);
    rd(a1, 8'hFF);
    rd(a2, 8'hFF);
    rd(a3, v3);
    run_op(OP_CHIP_ERASE, a3, 8'h00);
    rd(a3, 8'hFF);
    results();
  end
endmodule : flash_command_sequencer_bench
`default_nettype wire
